// File: bench/jlf_framer_bench.sv
`timescale 1ns/10ps
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: %s", $time, m); end end
// framer bench: registers, link bring-up, ila content, samples, test patterns
module jlf_framer_bench import jlf_pkg::*;;
  logic             clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic             low_go = 1'b0, pready, pslverr, sync_request_n, sample_take, lane1_en;
  logic [11:0]      paddr = 12'h000;
  logic [31:0]      pwdata = 32'h0, prdata, rd_q;
  logic [15:0]      sample_in = 16'h0000;
  logic [7:0]       low_len = 8'h00;
  logic             rd_err;
  jlf_octet_s [1:0] lane;
  jlf_octet_s       ila [2][256];
  int               n_fail = 0, cmp_count = 0;
  localparam jlf_octet_s O_R = {1'b1, SYM_K28_0};
  localparam jlf_octet_s O_A = {1'b1, SYM_K28_3};
  localparam jlf_octet_s O_Q = {1'b1, SYM_K28_4};
  localparam jlf_octet_s O_K = {1'b1, SYM_K28_5};

  jlf_framer dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_request_n(sync_request_n), .sample_in(sample_in), .sample_take(sample_take),
    .lane(lane), .lane1_en(lane1_en));
  jlf_rx_model rx (.clk(clk), .rst(rst), .lane0(lane[0]), .low_len(low_len),
    .low_go(low_go), .sync_request_n(sync_request_n));

  // clock and a sample source that changes every cycle
  always #2.5 clk = ~clk;
  always @(posedge clk) sample_in <= sample_in + 16'h1357;

  task automatic tally_and_finish;
    if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // request held from setup until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int t = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++t < 40);
    rd_q    = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (t >= 40) n_fail++;
    @(posedge clk);
  endtask : apb

  // expected configuration octet; counted fields carry value minus one
  function automatic logic [7:0] cfg_x(input int i, input logic two, input logic scr,
                                       input int k, input int lid);
    logic [7:0] v [14];
    v = '{8'h00, 8'h00, 8'(lid), {scr, 6'h00, two}, {7'h00, ~two}, 8'(k - 1), 8'h00,
          8'h0f, 8'h2f, 8'h20, {two, 7'h00}, 8'h00, 8'h00, 8'h00};
    v[13] = 8'(lid + 32 + k - 1) + {7'h00, scr} + {6'h00, two, 1'b0} + {7'h00, ~two};
    return v[i];
  endfunction : cfg_x

  // waits for sync release, then records and checks four ila multiframes
  task automatic link(input int k, input logic two, input logic scr, input logic rep);
    int kf;
    int t;
    kf = two ? k : 2 * k;
    @(posedge clk); // an octet launched before the restart may still be on the lane
    for (t = 0; t < 400 && sync_request_n !== 1'b1; t++) @(posedge clk);
    for (t = 0; t < kf + 8 && lane[0] !== O_R; t++) @(posedge clk);
    `CHK(t < kf + 8, 1'b1, "ila start")
    for (int i = 0; i < 4 * kf; i++) begin
      ila[0][i] = lane[0];
      ila[1][i] = lane[1];
      @(posedge clk);
    end
    `CHK(lane[0].is_k, rep, "after ila")
    for (int l = 0; l <= int'(two); l++) begin
      for (int m = 0; m < 4; m++) begin
        `CHK(ila[l][m * kf], O_R, "mf start")
        `CHK(ila[l][m * kf + kf - 1], O_A, "mf end")
      end
      `CHK(ila[l][kf + 1], O_Q, "cfg marker")
      `CHK(ila[l][kf + 4].data, 8'(l), "lane id")
      `CHK(ila[l][kf + 5].data[7], scr, "scr field")
      `CHK(ila[l][kf + 7].data, 8'(k - 1), "frames")
      for (int i = 0; i < 14; i++)
        `CHK(ila[l][kf + 2 + i].data, cfg_x(i, two, scr, k, l), "c")
    end
  endtask : link

  // self-synchronous descrambler 1 + x^14 + x^15, msb first; returns {history, octet}
  function automatic logic [22:0] dscr(input logic [14:0] h, input logic [7:0] o);
    logic [7:0] d;
    for (int i = 7; i >= 0; i--) begin
      d[i] = o[i] ^ h[13] ^ h[14];
      h    = {h[13:0], o[i]};
    end
    return {h, d};
  endfunction : dscr

  // follows six samples from capture to the lanes; scrambled octets are undone first
  task automatic data_chk(input logic two, input logic ramp, input logic [15:0] step,
                          input logic scr);
    logic [15:0] s, got, prev;
    logic [14:0] h;
    int t;
    h = 15'h0000;
    for (int j = 0; j < 6; j++) begin
      for (t = 0; t < 20 && sample_take !== 1'b1; t++) @(posedge clk);
      s = sample_in;
      @(posedge clk);
      got[15:8] = lane[0].data;
      `CHK(sample_take, two, "sample pace")
      if (!two) @(posedge clk);
      got[7:0] = lane[two].data;
      if (scr) begin
        {h, got[15:8]} = dscr(h, got[15:8]);
        {h, got[7:0]}  = dscr(h, got[7:0]);
      end
      `CHK(lane[0].is_k, 1'b0, "data octet")
      // the first scrambled sample has no history behind it yet
      if (!ramp && (!scr || j > 0)) `CHK(got, s, "sample octets")
      if (ramp && j > 0) `CHK(got, 16'(prev + step), "ramp")
      prev = got;
    end
  endtask : data_chk

  // pulls sync low for n cycles, then lets the link settle
  task automatic dip(input logic [7:0] n);
    low_len <= n;
    low_go  <= 1'b1;
    @(posedge clk);
    low_go  <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : dip

  // reset values, unmapped refusal, single lane with K below range
  task automatic sc_single;
    apb(1'b0, REG_CTRL, 32'h0);
    `CHK(rd_q, 32'h0, "ctrl reset")
    apb(1'b0, REG_KCFG, 32'h0);
    `CHK(rd_q, 32'h20, "kcfg reset")
    apb(1'b0, 12'h010, 32'h0);
    `CHK(rd_err, 1'b1, "unmapped")
    apb(1'b1, REG_KCFG, 32'h5);
    apb(1'b1, REG_CTRL, 32'h0);
    `CHK(lane1_en, 1'b0, "one lane")
    link(9, 1'b0, 1'b0, 1'b0);
    data_chk(1'b0, 1'b0, 16'h0, 1'b0);
  endtask : sc_single

  // a short dip is ignored, a long one breaks the link
  task automatic sc_break;
    dip(8'h05);
    `CHK(lane[0].is_k, 1'b0, "short dip")
    dip(8'h14);
    `CHK(lane[0], O_K, "link broken")
    link(9, 1'b0, 1'b0, 1'b0);
  endtask : sc_break

  // scrambled link keeps a plain ila; then two lanes at the lowest K
  task automatic sc_dual;
    apb(1'b1, REG_CTRL, 32'h2);
    link(9, 1'b0, 1'b1, 1'b0);
    data_chk(1'b0, 1'b0, 16'h0, 1'b1);
    apb(1'b1, REG_KCFG, 32'h11);
    apb(1'b1, REG_CTRL, 32'h1);
    link(17, 1'b1, 1'b0, 1'b0);
    `CHK(lane1_en, 1'b1, "two lanes")
    data_chk(1'b1, 1'b0, 16'h0, 1'b0);
  endtask : sc_dual

  // ramp after ila, then an ila that never ends
  task automatic sc_ramp;
    apb(1'b1, REG_STEP, 32'h3);
    apb(1'b1, REG_CTRL, 32'h40);
    link(17, 1'b0, 1'b0, 1'b0);
    data_chk(1'b0, 1'b1, 16'h3, 1'b0);
    apb(1'b1, REG_CTRL, 32'h30);
    link(17, 1'b0, 1'b0, 1'b1);
  endtask : sc_ramp

  // fixed symbols on both lanes
  task automatic sc_fixed;
    apb(1'b1, REG_CTRL, 32'h11);
    repeat (4) @(posedge clk);
    `CHK(lane, {2{1'b0, SYM_D21_5}}, "d21.5")
    apb(1'b1, REG_CTRL, 32'h21);
    repeat (4) @(posedge clk);
    `CHK(lane, {2{O_K}}, "k28.5")
  endtask : sc_fixed

  // each output bit must follow its generator recurrence, whatever the seed
  task automatic sc_prbs;
    logic [95:0] w;
    int a, b;
    for (int s = 5; s < 8; s++) begin
      a = s == 5 ? 7 : s == 6 ? 15 : 23;
      b = s == 5 ? 6 : s == 6 ? 14 : 18;
      apb(1'b1, REG_CTRL, 32'(s * 16));
      repeat (6) @(posedge clk);
      for (int i = 0; i < 12; i++) begin
        w = {w[87:0], lane[0].data};
        @(posedge clk);
      end
      for (int n = 23; n < 96; n++)
        `CHK(w[95 - n], w[95 - n + a] ^ w[95 - n + b], "prbs")
    end
  endtask : sc_prbs

  // reset for sixteen cycles, then the scenarios in turn
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    sc_single;
    sc_break;
    sc_dual;
    sc_ramp;
    sc_fixed;
    sc_prbs;
    tally_and_finish;
  end

  // watchdog: the sequence needs under a thousand cycles
  initial begin
    #200000;
    n_fail++;
    tally_and_finish;
  end
endmodule : jlf_framer_bench

// File: bench/jlf_rx_model.sv
`timescale 1ns/10ps
// receiver side: requests sync until it sees eight K28.5 in a row, then drops sync on demand
module jlf_rx_model import jlf_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire jlf_octet_s lane0,
  input  wire logic [7:0] low_len,
  input  wire logic       low_go,
  output logic            sync_request_n
);
  logic [3:0] lock_q;
  logic [7:0] hold_q;

  // lock count restarts on any other octet until it reaches eight, as a real aligner would
  always_ff @(posedge clk or posedge rst) begin
    if (rst) lock_q <= 4'h0;
    else if (lock_q != 4'h8) lock_q <= (lane0 == {1'b1, SYM_K28_5}) ? lock_q + 4'h1 : 4'h0;
  end

  // low span in cycles; the bench asks spans under and over four frames
  always_ff @(posedge clk or posedge rst) begin
    if (rst) hold_q <= 8'h00;
    else if (low_go) hold_q <= low_len;
    else if (hold_q != 8'h00) hold_q <= hold_q - 8'h01;
  end

  assign sync_request_n = (lock_q == 4'h8) && (hold_q == 8'h00);
endmodule : jlf_rx_model

// File: verilog/jlf_framer.sv
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
// Notes on behaviour
// - lanes per channel configurable, one or two
// - a lane never carries other channel data
// - single lane: twenty bits per sample
// - dual lane: ten bits per sample
// - octets, samples, density follow lane count only
// - lane count counts this channel only
// - unused configuration fields sent as zero
// - F and HD follow lane mode
// - frames per multiframe from register, clamped
// - lane ids zero, second lane one
// - resolution sixteen, one sample per frame
// - counted fields sent minus one
// - scrambling field mirrors enable register
// - scrambling off after reset, software enables
// - ILA octets never scrambled
// - selectable K28.5 and endless ILA tests
// - D21.5 test gives alternating bits
// - ramp test: ILA then stepping samples
// - PRBS7, PRBS15, PRBS23 test sequences
// - ILA at LMFC after release, four multiframes
module jlf_framer import jlf_pkg::*; (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             sync_request_n,
  input  wire logic [15:0]      sample_in,
  output logic                  sample_take,
  output jlf_octet_s [1:0]      lane,
  output logic                  lane1_en
);

  logic             two_q;
  logic             scr_q;
  jlf_test_e        tsel_q;
  logic [5:0]       kreg_q;
  logic [15:0]      step_q;
  logic [5:0]       kf;
  logic             oct_q;
  logic [5:0]       frm_q;
  logic [1:0]       mf_q;
  logic             frm_end;
  logic             mf_end;
  logic [6:0]       pos;
  logic [2:0]       sync_cnt_q;
  logic             sync_brk;
  jlf_state_e       st_q;
  jlf_state_e       st_d;
  logic [15:0]      ramp_q;
  logic [15:0]      hold_q;
  logic [15:0]      smp;
  logic [22:0]      prbs_q;
  logic [30:0]      prbs_nx;
  logic             is_prbs;
  logic             scr_on;
  logic [7:0]       raw [2];
  logic [7:0]       scr_out [2];
  jlf_octet_s [1:0] lane_d;
  logic             setup;
  logic             acc;
  logic             wr;
  logic             relink;

  // apb phases: the answer is ready in the first access cycle
  assign setup  = psel & ~penable;
  assign acc    = psel & penable & pready;
  assign wr     = acc & pwrite;
  assign relink = wr & ((paddr == REG_CTRL) || (paddr == REG_KCFG));

  // apb answer registers; unmapped addresses answer with pslverr
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~jlf_mapped(paddr);
      prdata  <= 32'h0000_0000;
      if (setup && !pwrite) begin
        case (paddr)
          REG_CTRL: prdata <= {25'h0, tsel_q, 2'h0, scr_q, two_q};
          REG_KCFG: prdata <= {26'h0, kreg_q};
          REG_STEP: prdata <= {16'h0, step_q};
          REG_STAT: prdata <= {18'h0, kf, 3'h0, sync_cnt_q, st_q};
          default:  prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // software configuration; scrambling starts disabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      two_q  <= 1'b0;
      scr_q  <= 1'b0;
      tsel_q <= TP_OFF;
      kreg_q <= K_RESET;
      step_q <= STEP_RESET;
    end else if (wr) begin
      case (paddr)
        REG_CTRL: begin
          two_q  <= pwdata[CTRL_TWO];
          scr_q  <= pwdata[CTRL_SCR];
          tsel_q <= jlf_test_e'(pwdata[CTRL_TSEL_LSB +: 3]);
        end
        REG_KCFG: kreg_q <= pwdata[5:0];
        REG_STEP: step_q <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // frame size comes from lane mode alone: two octets or one
  assign kf      = jlf_k_eff(kreg_q, two_q);
  assign frm_end = two_q | oct_q;
  assign mf_end  = frm_end & (frm_q >= kf - 6'h01);
  assign pos     = two_q ? {1'b0, frm_q} : {frm_q, oct_q};

  // octet, frame and multiframe counters; lmfc runs free
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oct_q <= 1'b0;
      frm_q <= 6'h00;
    end else begin
      oct_q <= two_q ? 1'b0 : ~oct_q;
      if (mf_end) begin
        frm_q <= 6'h00;
      end else if (frm_end) begin
        frm_q <= frm_q + 6'h01;
      end
    end
  end

  // short low pulses on sync never reach the break threshold
  assign sync_brk = ~sync_request_n & (sync_cnt_q == SYNC_MIN_FRAMES);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_cnt_q <= 3'h0;
    end else if (sync_request_n) begin
      sync_cnt_q <= 3'h0;
    end else if (frm_end && sync_cnt_q != SYNC_MIN_FRAMES) begin
      sync_cnt_q <= sync_cnt_q + 3'h1;
    end
  end

  // link sequence: K28.5 until released, ILA, then samples
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_CGS: begin
        if (sync_request_n && mf_end) st_d = ST_ILA;
      end
      ST_ILA: begin
        if (mf_end && mf_q == ILA_LAST_MF && tsel_q != TP_ILA) st_d = ST_DATA;
      end
      ST_DATA: st_d = ST_DATA;
      default: st_d = ST_CGS;
    endcase
    // reconfiguring the frame layout must restart the link
    if (sync_brk || relink) st_d = ST_CGS;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_CGS;
    end else begin
      st_q <= st_d;
    end
  end

  // multiframe count inside the ILA; wraps for the endless test
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mf_q <= 2'h0;
    end else if (st_q != ST_ILA) begin
      mf_q <= 2'h0;
    end else if (mf_end) begin
      mf_q <= mf_q + 2'h1;
    end
  end

  // sample taken once per frame: two octets on one lane, one on each of two
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sample_take <= 1'b0;
    end else begin
      sample_take <= (st_d == ST_DATA) & (two_q | oct_q);
    end
  end

  assign smp = (tsel_q == TP_RAMP) ? ramp_q : sample_in;

  // ramp restarts at zero with every new ILA
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ramp_q <= 16'h0000;
      hold_q <= 16'h0000;
    end else begin
      if (st_q != ST_DATA) begin
        ramp_q <= 16'h0000;
      end else if (sample_take && tsel_q == TP_RAMP) begin
        ramp_q <= ramp_q + step_q;
      end
      if (sample_take) hold_q <= smp;
    end
  end

  assign is_prbs = (tsel_q == TP_PRBS7) || (tsel_q == TP_PRBS15) || (tsel_q == TP_PRBS23);
  assign prbs_nx = jlf_prbs8(prbs_q, tsel_q);

  // generator reseeds whenever a pattern other than PRBS7, PRBS15 or PRBS23 is chosen
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prbs_q <= PRBS_SEED;
    end else begin
      prbs_q <= is_prbs ? prbs_nx[22:0] : PRBS_SEED;
    end
  end

  // lane 0 carries the msb octet, then lsb or lane 1 takes it
  assign raw[0] = (two_q | ~oct_q) ? smp[15:8] : hold_q[7:0];
  assign raw[1] = smp[7:0];

  // only sample octets pass the scrambler, never the ILA
  assign scr_on = (st_q == ST_DATA) & scr_q & ((tsel_q == TP_OFF) || (tsel_q == TP_RAMP));

  for (genvar l = 0; l < 2; l++) begin : g_scr
    jlf_scrambler u_scr (
      .clk  (clk),
      .rst  (rst),
      .adv  (scr_on),
      .din  (raw[l]),
      .dout (scr_out[l])
    );
  end

  // octet selection per lane; the D21.5, K28.5 and PRBS test patterns override the link
  always_comb begin
    for (int l = 0; l < 2; l++) begin
      lane_d[l] = '{is_k: 1'b1, data: SYM_K28_5};
      case (st_q)
        ST_ILA: begin
          if (pos == 7'h00) begin
            lane_d[l] = '{is_k: 1'b1, data: SYM_K28_0};
          end else if (mf_end) begin
            lane_d[l] = '{is_k: 1'b1, data: SYM_K28_3};
          end else if (mf_q == 2'h1 && pos == 7'h01) begin
            lane_d[l] = '{is_k: 1'b1, data: SYM_K28_4};
          end else if (mf_q == 2'h1 && pos < CFG_END) begin
            lane_d[l] = '{is_k: 1'b0,
                          data: jlf_cfg_octet(4'(pos - CFG_FIRST), two_q, scr_q, kf,
                                              1'(l))};
          end else begin
            lane_d[l] = '{is_k: 1'b0, data: {1'b0, pos}};
          end
        end
        ST_DATA: lane_d[l] = '{is_k: 1'b0, data: scr_on ? scr_out[l] : raw[l]};
        default: ;
      endcase
      case (tsel_q)
        TP_D215: lane_d[l] = '{is_k: 1'b0, data: SYM_D21_5};
        TP_K285: lane_d[l] = '{is_k: 1'b1, data: SYM_K28_5};
        TP_PRBS7, TP_PRBS15, TP_PRBS23: begin
          lane_d[l] = '{is_k: 1'b0, data: prbs_nx[30:23]};
        end
        default: ;
      endcase
      // second lane idles in single-lane mode
      if (l == 1 && !two_q) lane_d[l] = '{is_k: 1'b0, data: 8'h00};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lane     <= '0;
      lane1_en <= 1'b0;
    end else begin
      lane     <= lane_d;
      lane1_en <= two_q;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_lane1_idle: assert property (!two_q |=> !lane1_en && lane[1] == '0)
    else $error("second lane active in single-lane mode");

  a_single_rate: assert property (!two_q && sample_take && !relink |=> !sample_take)
    else $error("single lane took samples on consecutive octets");

  a_dual_rate: assert property (two_q && st_q == ST_DATA && st_d == ST_DATA |-> sample_take)
    else $error("dual lane missed a sample");

  a_ila_start: assert property (st_q == ST_CGS ##1 st_q == ST_ILA |-> pos == 7'h00)
    else $error("ILA did not start on a multiframe boundary");

  a_ila_length: assert property ($rose(st_q == ST_DATA) |-> $past(mf_q) == ILA_LAST_MF)
    else $error("ILA was not four multiframes long");

  a_sync_short: assert property (st_q == ST_DATA && sync_cnt_q < 3'h3 && !relink
                                 |=> st_q == ST_DATA)
    else $error("short sync pulse broke the link");

  a_d215_out: assert property (tsel_q == TP_D215 |=> lane[0] == {1'b0, SYM_D21_5})
    else $error("D21.5 pattern missing");

  a_k_range: assert property (kf <= K_MAX && kf >= (two_q ? K_MIN_TWO : K_MIN_ONE))
    else $error("frames per multiframe out of range");

  a_msb_first: assert property (sample_take && !two_q && !scr_on && tsel_q == TP_OFF
                                |=> lane[0].data == $past(sample_in[15:8]))
    else $error("msb octet not sent first");

  a_ila_clear: assert property (st_q == ST_ILA |-> !scr_on)
    else $error("ILA octet passed the scrambler");

endmodule : jlf_framer

// File: verilog/jlf_pkg.sv
package jlf_pkg;

  // register byte addresses
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_KCFG = 12'h004;
  localparam logic [11:0] REG_STEP = 12'h008;
  localparam logic [11:0] REG_STAT = 12'h00c;

  // control field positions
  localparam int CTRL_TWO      = 0;
  localparam int CTRL_SCR      = 1;
  localparam int CTRL_TSEL_LSB = 4;

  // values after reset and legal frame counts
  localparam logic [5:0]  K_RESET    = 6'h20;
  localparam logic [5:0]  K_MIN_ONE  = 6'h09;
  localparam logic [5:0]  K_MIN_TWO  = 6'h11;
  localparam logic [5:0]  K_MAX      = 6'h20;
  localparam logic [15:0] STEP_RESET = 16'h0001;
  localparam logic [22:0] PRBS_SEED  = 23'h7fffff;
  localparam logic [14:0] SCR_SEED   = 15'h0000;

  // link sequencing counts
  localparam logic [2:0] SYNC_MIN_FRAMES = 3'h4;
  localparam logic [1:0] ILA_LAST_MF     = 2'h3;
  localparam logic [6:0] CFG_FIRST       = 7'h02;
  localparam logic [6:0] CFG_END         = 7'h10;

  // control and data symbols
  localparam logic [7:0] SYM_K28_0 = 8'h1c;
  localparam logic [7:0] SYM_K28_3 = 8'h7c;
  localparam logic [7:0] SYM_K28_4 = 8'h9c;
  localparam logic [7:0] SYM_K28_5 = 8'hbc;
  localparam logic [7:0] SYM_D21_5 = 8'hb5;

  typedef enum logic [2:0] {
    TP_OFF, TP_D215, TP_K285, TP_ILA, TP_RAMP, TP_PRBS7, TP_PRBS15, TP_PRBS23
  } jlf_test_e;

  typedef enum logic [1:0] {ST_CGS, ST_ILA, ST_DATA} jlf_state_e;

  typedef struct packed {
    logic       is_k;
    logic [7:0] data;
  } jlf_octet_s;

  // clamp frames per multiframe to the range legal for the lane mode
  function automatic logic [5:0] jlf_k_eff(input logic [5:0] k, input logic two);
    logic [5:0] lo;
    lo = two ? K_MIN_TWO : K_MIN_ONE;
    if (k < lo) return lo;
    if (k > K_MAX) return K_MAX;
    return k;
  endfunction : jlf_k_eff

  function automatic logic jlf_mapped(input logic [11:0] a);
    return (a == REG_CTRL) || (a == REG_KCFG) || (a == REG_STEP) || (a == REG_STAT);
  endfunction : jlf_mapped

  // link configuration octet idx; unused fields are zero
  function automatic logic [7:0] jlf_cfg_octet(input logic [3:0] idx, input logic two,
                                               input logic scr, input logic [5:0] k,
                                               input logic lid);
    logic [7:0] sum;
    // field sum: lid, scr, l-1, f-1, k-1, n-1, subclass, n'-1, version, hd
    sum = {7'h00, lid} + {7'h00, scr} + {7'h00, two} + {7'h00, ~two}
        + {2'h0, k - 6'h01} + 8'h0f + 8'h01 + 8'h0f + 8'h01 + {7'h00, two};
    case (idx)
      4'h2:    return {7'h00, lid};
      4'h3:    return {scr, 6'h00, two};
      4'h4:    return {7'h00, ~two};             // f-1
      4'h5:    return {3'h0, 5'(k - 6'h01)};
      4'h7:    return 8'h0f;                     // n-1
      4'h8:    return 8'h2f;                     // subclass 1, n'-1
      4'h9:    return 8'h20;                     // version 1, s-1
      4'ha:    return {two, 7'h00};              // hd
      4'hd:    return sum;
      default: return 8'h00;
    endcase
  endfunction : jlf_cfg_octet

  // eight pseudo-random bits per call, msb first
  function automatic logic [30:0] jlf_prbs8(input logic [22:0] s, input jlf_test_e sel);
    logic [22:0] st;
    logic [7:0]  o;
    logic        fb;
    st = s;
    o  = 8'h00;
    fb = 1'b0;
    for (int i = 0; i < 8; i++) begin
      case (sel)
        TP_PRBS7:  fb = st[6] ^ st[5];
        TP_PRBS15: fb = st[14] ^ st[13];
        default:   fb = st[22] ^ st[17];
      endcase
      st = {st[21:0], fb};
      o  = {o[6:0], fb};
    end
    return {o, st};
  endfunction : jlf_prbs8

endpackage : jlf_pkg

// File: verilog/jlf_scrambler.sv
`timescale 1ns/10ps
// self-synchronous 1 + x^14 + x^15 scrambler, one octet a cycle, msb first
module jlf_scrambler import jlf_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       adv,
  input  wire logic [7:0] din,
  output logic      [7:0] dout
);
  logic [14:0] hist_q;
  logic [14:0] hist_d;

  // history holds the last fifteen scrambled bits
  always_comb begin
    hist_d = hist_q;
    dout   = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      dout[i] = din[i] ^ hist_d[13] ^ hist_d[14];
      hist_d  = {hist_d[13:0], dout[i]};
    end
  end

  // only advance on octets that are really scrambled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hist_q <= SCR_SEED;
    end else if (adv) begin
      hist_q <= hist_d;
    end
  end

endmodule : jlf_scrambler
